// ==== pkg/tap_pkg.sv ====
// Purpose: shared constants and types for the memory boundary-scan test port
// Assumes: one 100 MHz system clock that oversamples the serial test clock
// Notes:   instruction codes and the identification value are free to change

package tap_pkg;

    // serial pins as sampled from the board
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    // instruction register width and codes
    localparam int        IR_LEN        = 3;
    localparam logic [2:0] OP_EXTEST    = 3'h0;
    localparam logic [2:0] OP_IDCODE    = 3'h1;
    localparam logic [2:0] OP_SAMPLE_Z  = 3'h2;
    localparam logic [2:0] OP_RSVD_A    = 3'h3;
    localparam logic [2:0] OP_SAMPLE_PL = 3'h4;
    localparam logic [2:0] OP_RSVD_B    = 3'h5;
    localparam logic [2:0] OP_RSVD_C    = 3'h6;
    localparam logic [2:0] OP_BYPASS    = 3'h7;

    // value forced into all instruction shift bits on capture
    localparam logic [2:0] IR_CAPTURE   = 3'h1;

    // identification register; the value is arbitrary, lsb kept at one
    localparam int         ID_LEN       = 32;
    localparam logic [31:0] ID_CODE     = 32'h0A5C_3001;

    // boundary chain length and the cell that gates the output bus
    localparam int         BSR_LEN      = 109;
    localparam int         BSR_TRI_BIT  = 108;

    // consecutive high mode-select edges that force reset
    localparam int         RESET_ONES   = 5;

    // sixteen controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SH_DR   = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAU_DR  = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SH_IR   = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAU_IR  = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } tap_state_t;

endpackage : tap_pkg

// ==== tb/scan_master.sv ====
// Purpose: behavioural test controller that drives the serial test pins
// Assumes: tck stands low between bits; one bit per 125 ns tck period
// Notes:   only the standard controller paths are walked, never reserved codes

`timescale 1ns/100ps

module scan_master (
    // serial pins
    output tap_pkg::tap_pins_t pins,
    input  wire logic          tdo,
    input  wire logic          tdo_oe,
    // shift bits seen without output enable
    output int                 oe_miss
);

    // unused inputs idle high, as the pad pull-ups would leave them
    initial
    begin
        pins    = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
        oe_miss = 0;
    end

    // one tck period; output read late in the low phase, well after its fall
    task automatic tick(input logic tms, input logic tdi, output logic got, output logic oe);
        pins.tms = tms;
        pins.tdi = tdi;
        #60;
        got      = tdo;
        oe       = tdo_oe;
        pins.tck = 1'b1;
        #62.5;
        pins.tck = 1'b0;
        #2.5;
    endtask : tick

    // idle, capture, n bits lsb first, update, back to idle
    task automatic shift(input logic is_ir, input logic [127:0] din, input int n,
                         output logic [127:0] dout);
        logic b;
        logic o;
        dout = '0;
        tick(1'b1, 1'b1, b, o);
        if (is_ir)
        begin
            tick(1'b1, 1'b1, b, o);
        end
        tick(1'b0, 1'b1, b, o);
        tick(1'b0, 1'b1, b, o);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], dout[i], o);
            if (o !== 1'b1)
            begin
                oe_miss++;
            end
        end
        tick(1'b1, 1'b1, b, o);
        tick(1'b0, 1'b1, b, o);
    endtask : shift

    // five high mode-select rises force the controller to reset
    task automatic ones(input int n);
        logic b;
        logic o;
        repeat (n) tick(1'b1, 1'b1, b, o);
    endtask : ones

endmodule : scan_master

// ==== tb/sram_boundary_scan_tap_tb.sv ====
// Purpose: self-checking bench of the memory boundary-scan test port
// Assumes: default boundary chain length; tck made by the controller model
// Notes:   released tdo is modelled as the inverse of its last driven value

`timescale 1ns/100ps

`define check(nm, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("wrong value %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module sram_boundary_scan_tap_tb;

    localparam logic [108:0] PAT_A = {1'b1, {27{4'h6}}};
    localparam logic [108:0] PAT_B = {1'b0, {27{4'hB}}};
    localparam logic [108:0] PAT_C = {1'b1, {27{4'h9}}};

    logic               clk;
    logic               nrst;
    tap_pkg::tap_pins_t pins;
    logic               tdo_q;
    logic               tdo_oe_q;
    logic               tdo_last = 1'b0;
    logic               tdo_w;
    logic               extest_q;
    logic               out_bus_hiz_q;
    logic [108:0]       ring_in;
    logic [108:0]       ring_drive_q;
    logic [127:0]       dout;
    int                 oe_miss;
    int                 fail_count;
    int                 cmp_count;

    sram_scan_tap sram_scan_tap_inst (.clk(clk), .nrst(nrst), .pins(pins), .tdo_q(tdo_q),
        .tdo_oe_q(tdo_oe_q), .ring_in(ring_in), .ring_drive_q(ring_drive_q),
        .extest_q(extest_q), .out_bus_hiz_q(out_bus_hiz_q));
    scan_master scan_master_inst (.pins(pins), .tdo(tdo_w), .tdo_oe(tdo_oe_q),
        .oe_miss(oe_miss));

    // released line shows no stale value, so a missing enable shows as bad data
    assign tdo_w = tdo_oe_q ? tdo_q : ~tdo_last;
    always @(posedge clk)
    begin
        if (tdo_oe_q === 1'b1)
        begin
            tdo_last <= tdo_q;
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic load_ir(input logic [2:0] op);
        scan_master_inst.shift(1'b1, {125'h0, op}, 3, dout);
    endtask : load_ir

    // reset values, then one low mode-select rise to leave reset for idle
    task automatic s_power_up;
        logic b;
        logic o;
        `check("oe", 1'b0, tdo_oe_q)
        `check("extest", 1'b0, extest_q)
        `check("hiz", 1'b0, out_bus_hiz_q)
        `check("preset", 109'h1 << 108, ring_drive_q)
        scan_master_inst.tick(1'b0, 1'b1, b, o);
    endtask : s_power_up

    // identification read, then extra bits show tdi entering at the msb
    task automatic s_idcode;
        scan_master_inst.shift(1'b0, {92'h0, 36'h0_0000_0009}, 36, dout);
        `check("id", tap_pkg::ID_CODE, dout[31:0])
        `check("msb in", 4'h9, dout[35:32])
        `check("oe miss", 0, oe_miss)
        `check("oe idle", 1'b0, tdo_oe_q)
    endtask : s_idcode

    // capture pattern on instruction path, then one-bit bypass path
    task automatic s_bypass;
        load_ir(tap_pkg::OP_BYPASS);
        `check("ir cap", tap_pkg::IR_CAPTURE, dout[2:0])
        scan_master_inst.shift(1'b0, {123'h0, 5'h16}, 5, dout);
        `check("byp zero", 1'b0, dout[0])
        `check("byp path", 4'h6, dout[4:1])
    endtask : s_bypass

    // every implemented code and its effect on the memory output controls
    task automatic s_opcodes;
        logic [2:0] ops [5] = '{tap_pkg::OP_EXTEST, tap_pkg::OP_IDCODE, tap_pkg::OP_SAMPLE_Z,
                                tap_pkg::OP_SAMPLE_PL, tap_pkg::OP_BYPASS};
        logic [1:0] exp [5] = '{2'h2, 2'h0, 2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 5; i++)
        begin
            load_ir(ops[i]);
            `check("ext hiz", exp[i], {extest_q, out_bus_hiz_q})
        end
    endtask : s_opcodes

    // capture and preload of the boundary chain under the three capture codes
    task automatic s_ring;
        @(negedge clk) ring_in = PAT_A;
        load_ir(tap_pkg::OP_SAMPLE_PL);
        scan_master_inst.shift(1'b0, {19'h0, PAT_B}, 109, dout);
        `check("cap pl", PAT_A, dout[108:0])
        `check("preload", PAT_B, ring_drive_q)
        load_ir(tap_pkg::OP_EXTEST);
        `check("ext hiz", 2'h3, {extest_q, out_bus_hiz_q})
        @(negedge clk) ring_in = PAT_C;
        scan_master_inst.shift(1'b0, {19'h0, PAT_B}, 109, dout);
        `check("cap ext", PAT_C, dout[108:0])
        load_ir(tap_pkg::OP_SAMPLE_Z);
        @(negedge clk) ring_in = PAT_A;
        scan_master_inst.shift(1'b0, {19'h0, PAT_C}, 109, dout);
        `check("cap z", PAT_A, dout[108:0])
        `check("z held", 2'h1, {extest_q, out_bus_hiz_q})
        `check("no upd", PAT_B, ring_drive_q)
    endtask : s_ring

    // mode-select reset from mid shift restores the identification code
    task automatic s_tms_reset;
        logic b;
        logic o;
        scan_master_inst.tick(1'b1, 1'b1, b, o);
        scan_master_inst.tick(1'b0, 1'b1, b, o);
        scan_master_inst.tick(1'b0, 1'b1, b, o);
        scan_master_inst.ones(6);
        `check("rst ctl", 2'h0, {extest_q, out_bus_hiz_q})
        `check("rst preset", 1'b1, ring_drive_q[108])
        `check("rst oe", 1'b0, tdo_oe_q)
        scan_master_inst.tick(1'b0, 1'b1, b, o);
        scan_master_inst.shift(1'b0, 128'h0, 32, dout);
        `check("rst id", tap_pkg::ID_CODE, dout[31:0])
    endtask : s_tms_reset

    initial
    begin
        nrst       = 1'b0;
        ring_in    = '0;
        fail_count = 0;
        cmp_count  = 0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        s_power_up;
        s_idcode;
        s_bypass;
        s_opcodes;
        s_ring;
        s_tms_reset;
        close_out;
    end

    // whole sequence needs roughly 65 us of tck traffic
    initial
    begin
        #400000;
        fail_count++;
        close_out;
    end

endmodule : sram_boundary_scan_tap_tb

// ==== verilog/sram_scan_tap.sv ====
// Purpose: boundary-scan test port of a burst memory, oversampled on clk
// Assumes: test clock well below clk/4; pin ring and pins are asynchronous
// Notes:   pull-ups on the serial inputs live in the pad ring

`timescale 1ns/100ps

module sram_scan_tap #(
    parameter int BSR_W = tap_pkg::BSR_LEN
) (
    // system
    input  wire logic                clk,
    input  wire logic                nrst,
    // serial test pins
    input  wire tap_pkg::tap_pins_t  pins,
    output logic                     tdo_q,
    output logic                     tdo_oe_q,
    // pin ring
    input  wire logic [BSR_W-1:0]    ring_in,
    output logic      [BSR_W-1:0]    ring_drive_q,
    output logic                     extest_q,
    output logic                     out_bus_hiz_q
);

    // synchronisers: first stage feeds only the second
    logic [2:0]       pin_s1_q;
    logic [2:0]       pin_s2_q;
    logic             tck_prev_q;
    logic [BSR_W-1:0] ring_s1_q;
    logic [BSR_W-1:0] ring_s2_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            // idle levels: tck low, tms and tdi high, so no false edge on release
            pin_s1_q   <= 3'h3;
            pin_s2_q   <= 3'h3;
            tck_prev_q <= 1'b0;
        end
        else
        begin
            pin_s1_q   <= pins;
            pin_s2_q   <= pin_s1_q;
            tck_prev_q <= pin_s2_q[2];
        end
    end

    // ring is synchronised every clk, taken into the chain only on capture; a moving pin may capture either value
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ring_s1_q <= '0;
            ring_s2_q <= '0;
        end
        else
        begin
            ring_s1_q <= ring_in;
            ring_s2_q <= ring_s1_q;
        end
    end

    // test-clock edges found by the system clock
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;
    assign tck_s    = pin_s2_q[2];
    assign tms_s    = pin_s2_q[1];
    assign tdi_s    = pin_s2_q[0];
    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    // controller state
    tap_pkg::tap_state_t state_q;
    tap_pkg::tap_state_t state_d;

    // next state from sampled mode-select
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            tap_pkg::ST_RESET:  state_d = tms_s ? tap_pkg::ST_RESET  : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:   state_d = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: state_d = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR: state_d = tms_s ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_SH_DR:  state_d = tms_s ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_EX1_DR: state_d = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
            tap_pkg::ST_PAU_DR: state_d = tms_s ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
            tap_pkg::ST_EX2_DR: state_d = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_UPD_DR: state_d = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: state_d = tms_s ? tap_pkg::ST_RESET  : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR: state_d = tms_s ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_SH_IR:  state_d = tms_s ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_EX1_IR: state_d = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
            tap_pkg::ST_PAU_IR: state_d = tms_s ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
            tap_pkg::ST_EX2_IR: state_d = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_UPD_IR: state_d = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default:            state_d = tap_pkg::ST_RESET;
        endcase
    end

    // advance only on rising test-clock edges; high mode-select drifts to reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_q <= tap_pkg::ST_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end

    // state decodes
    logic in_reset;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    assign in_reset = (state_q == tap_pkg::ST_RESET);
    assign cap_ir   = (state_q == tap_pkg::ST_CAP_IR);
    assign sh_ir    = (state_q == tap_pkg::ST_SH_IR);
    assign upd_ir   = (state_q == tap_pkg::ST_UPD_IR);
    assign cap_dr   = (state_q == tap_pkg::ST_CAP_DR);
    assign sh_dr    = (state_q == tap_pkg::ST_SH_DR);
    assign upd_dr   = (state_q == tap_pkg::ST_UPD_DR);

    // instruction shift stage and active instruction
    logic [tap_pkg::IR_LEN-1:0] ir_sh_q;
    logic [tap_pkg::IR_LEN-1:0] ir_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ir_sh_q <= tap_pkg::OP_IDCODE;
            ir_q    <= tap_pkg::OP_IDCODE;
        end
        else if (tck_rise)
        begin
            if (cap_ir)
                ir_sh_q <= tap_pkg::IR_CAPTURE;
            else if (sh_ir)
                ir_sh_q <= {tdi_s, ir_sh_q[2:1]};
            if (in_reset)
                ir_q <= tap_pkg::OP_IDCODE;
            else if (upd_ir)
                ir_q <= ir_sh_q;
        end
    end

    // data register selection; reserved codes fall back to bypass
    logic sel_bsr;
    logic sel_id;
    logic sel_byp;
    assign sel_bsr = (ir_q == tap_pkg::OP_EXTEST) | (ir_q == tap_pkg::OP_SAMPLE_PL)
                   | (ir_q == tap_pkg::OP_SAMPLE_Z);
    assign sel_id  = (ir_q == tap_pkg::OP_IDCODE);
    assign sel_byp = ~sel_bsr & ~sel_id;

    // data registers
    logic                       byp_q;
    logic [tap_pkg::ID_LEN-1:0] id_sh_q;
    logic [BSR_W-1:0]           bsr_sh_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            byp_q    <= 1'b0;
            id_sh_q  <= '0;
            bsr_sh_q <= '0;
        end
        else if (tck_rise)
        begin
            if (cap_dr && sel_byp)
                byp_q <= 1'b0;
            else if (sh_dr && sel_byp)
                byp_q <= tdi_s;
            if (cap_dr && sel_id)
                id_sh_q <= tap_pkg::ID_CODE;
            else if (sh_dr && sel_id)
                id_sh_q <= {tdi_s, id_sh_q[tap_pkg::ID_LEN-1:1]};
            if (cap_dr && sel_bsr)
                bsr_sh_q <= ring_s2_q;
            else if (sh_dr && sel_bsr)
                bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_W-1:1]};
        end
    end

    // update stage of the chain; tri-state cell presets high on reset
    logic [BSR_W-1:0] bsr_upd_q;
    localparam logic [BSR_W-1:0] BSR_UPD_INIT = BSR_W'(1) << tap_pkg::BSR_TRI_BIT;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bsr_upd_q <= BSR_UPD_INIT;
        else if (tck_rise && in_reset)
            bsr_upd_q <= BSR_UPD_INIT;
        else if (tck_rise && upd_dr && sel_bsr && (ir_q != tap_pkg::OP_SAMPLE_Z))
            bsr_upd_q <= bsr_sh_q;
    end

    // serial output source picked by state then instruction
    logic tdo_d;
    logic shifting;
    assign shifting = sh_ir | sh_dr;
    assign tdo_d    = sh_ir   ? ir_sh_q[0]
                    : sel_bsr ? bsr_sh_q[0]
                    : sel_id  ? id_sh_q[0]
                    : byp_q;

    // serial output changes on the falling edge only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_q    <= shifting ? tdo_d : 1'b0;
            tdo_oe_q <= shifting;
        end
    end

    // pin-ring controls; follow the active instruction and the update stage, never the memory core
    logic hiz_d;
    assign hiz_d = (ir_q == tap_pkg::OP_SAMPLE_Z)
                 | ((ir_q == tap_pkg::OP_EXTEST) & ~bsr_upd_q[tap_pkg::BSR_TRI_BIT]);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ring_drive_q  <= BSR_UPD_INIT;
            extest_q      <= 1'b0;
            out_bus_hiz_q <= 1'b0;
        end
        else
        begin
            ring_drive_q  <= bsr_upd_q;
            extest_q      <= (ir_q == tap_pkg::OP_EXTEST);
            out_bus_hiz_q <= hiz_d;
        end
    end

    // helper: consecutive high mode-select rising edges, saturating
    logic [2:0] ones_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ones_q <= 3'h0;
        else if (tck_rise)
            ones_q <= !tms_s ? 3'h0 : (ones_q == 3'h5) ? ones_q : ones_q + 3'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_rise_in_cap_ir;
        tck_rise && cap_ir;
    endsequence

    sequence s_rise_shift_ir;
        tck_rise && sh_ir;
    endsequence

    a_edge_only_moves: assert property (
        (state_q != $past(state_q)) |-> $past(tck_rise))
        else $error("state moved without a test-clock rise");

    a_five_ones_reset: assert property (
        (ones_q == 3'h5) |-> in_reset)
        else $error("five high mode-select edges did not reach reset");

    a_reset_idcode: assert property (
        (tck_rise && in_reset) |=> (ir_q == tap_pkg::OP_IDCODE))
        else $error("instruction not identification after reset");

    a_capture_pattern: assert property (
        s_rise_in_cap_ir |=> (ir_sh_q[1:0] == 2'h1))
        else $error("instruction capture pattern wrong");

    a_tdi_into_msb: assert property (
        s_rise_shift_ir |=> (ir_sh_q[2] == $past(tdi_s)))
        else $error("serial input did not enter msb");

    a_ir_update_only: assert property (
        (ir_q != $past(ir_q)) |-> $past(tck_rise && (upd_ir || in_reset)))
        else $error("instruction changed outside update");

    a_tdo_released: assert property (
        (tck_fall && !shifting) |=> !tdo_oe_q)
        else $error("serial output enabled outside shift");

    a_bypass_cleared: assert property (
        (tck_rise && cap_dr && sel_byp) |=> !byp_q)
        else $error("bypass not cleared on capture");

    a_id_capture: assert property (
        (tck_rise && cap_dr && sel_id) |=> (id_sh_q == tap_pkg::ID_CODE))
        else $error("identification code not captured");

    a_float_holds: assert property (
        (ir_q == tap_pkg::OP_SAMPLE_Z) ##1 (ir_q == tap_pkg::OP_SAMPLE_Z) |-> out_bus_hiz_q)
        else $error("float-sample did not release output bus");

endmodule : sram_scan_tap
